/* rtl/rtec_pkg.sv */
// Package of constants and types for the task end and capture block
package rtec_pkg;

    // ==========================================================
    // Capture selector codes
    localparam logic [1:0] CAP_OFF = 2'h0;
    localparam logic [1:0] CAP_START_ALL = 2'h1;
    localparam logic [1:0] CAP_END_ALL = 2'h2;
    localparam logic [1:0] CAP_START_FIRST = 2'h3;

    // ==========================================================
    // End cause codes
    localparam logic [7:0] END_NORMAL = 8'h00;
    localparam logic [7:0] END_SYNC_WAIT_STOPPED = 8'h01;
    localparam logic [7:0] END_SYNC_TIMEOUT = 8'h02;
    localparam logic [7:0] END_CHANNEL_BUSY = 8'h03;
    localparam logic [7:0] END_RETRY_LIMIT = 8'h04;
    localparam logic [7:0] END_STOPPED = 8'h05;
    localparam logic [7:0] END_ABORTED = 8'h06;
    localparam logic [7:0] ERR_INTERNAL_PROGRAM = 8'hff;
    localparam logic [7:0] ERR_UNKNOWN_COMMAND = 8'hfe;
    localparam logic [7:0] ERR_SEMAPHORE_UNAVAILABLE = 8'hfd;
    localparam logic [7:0] ERR_BAD_PARAMETER = 8'hfc;
    localparam logic [7:0] ERR_TX_FIFO_EMPTY = 8'hfb;
    localparam logic [7:0] ERR_RX_FIFO_OVERFULL = 8'hfa;
    localparam logic [7:0] ERR_MODULATOR_UNDERFLOW = 8'hf9;

    // ==========================================================
    // Register map (index = byte address here)
    localparam logic [3:0] ADDR_RADIO_CONFIGURATION = 4'h0;
    localparam logic [3:0] ADDR_CHANNEL = 4'h1;
    localparam logic [3:0] ADDR_TASK_END_REASON = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_CAPTURE = 4'h4;

    // Field positions
    localparam int TX_CAPTURE_SELECT_LSB = 0;
    localparam int RX_CAPTURE_SELECT_LSB = 2;
    localparam int KEEP_SYNTH_BIT = 7;
    localparam int CHAN_FREQ_LSB = 0;
    localparam logic [6:0] FREQ_KEEP = 7'h7f;

    // Reset values
    localparam logic [7:0] RADIO_CONF_RESET = 8'h00;
    localparam logic [7:0] CHANNEL_RESET = 8'h00;
    localparam logic [7:0] END_REASON_RESET = 8'h00;

    // ==========================================================
    // Task end requests from the sequencer
    typedef enum logic [3:0] {
        RTEC_FIN_NORMAL,
        RTEC_FIN_SYNC_STOP,
        RTEC_FIN_SYNC_TIMEOUT,
        RTEC_FIN_BUSY,
        RTEC_FIN_RETRY,
        RTEC_FIN_STOP,
        RTEC_FIN_INTERNAL,
        RTEC_FIN_BAD_CMD,
        RTEC_FIN_SEM,
        RTEC_FIN_PARAM,
        RTEC_FIN_TXFIFO,
        RTEC_FIN_RXFIFO,
        RTEC_FIN_MODUNF
    } rtec_fin_t;

    typedef enum logic [1:0] {
        RTEC_IDLE,
        RTEC_RUN,
        RTEC_HALT
    } rtec_state_t;

    // Packet events from the radio datapath
    typedef struct packed {
        logic tx_sync;
        logic tx_end;
        logic rx_sync;
        logic rx_end;
    } rtec_pkt_t;

    // Register port
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rtec_bus_t;

endpackage : rtec_pkg

/* rtl/rtec_capture.sv */
// Per-direction capture decision for packet timestamps
`timescale 1ns/100ps
module rtec_capture (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [1:0] i_select,
    input wire logic i_task_start,
    input wire logic i_sync,
    input wire logic i_end,
    output logic o_fire
);
    // ==========================================================
    // State
    typedef struct packed {
        logic first_done;
        logic fire;
    } rtec_cap_state_t;

    rtec_cap_state_t st_reg;
    rtec_cap_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.fire = 1'b0;
        // Rearm first, so a packet end in the same cycle still closes
        if (i_task_start) begin
            st_next.first_done = 1'b0;
        end
        unique case (i_select)
            rtec_pkg::CAP_OFF: st_next.fire = 1'b0;
            rtec_pkg::CAP_START_ALL: st_next.fire = i_sync;
            rtec_pkg::CAP_END_ALL: st_next.fire = i_end;
            rtec_pkg::CAP_START_FIRST: begin
                // Closes only on packet end, start stays armed until then
                st_next.fire = i_sync && !st_reg.first_done;
                if (i_end) begin
                    st_next.first_done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_fire = st_reg.fire;
endmodule : rtec_capture

/* rtl/rtec_task_end.sv */
// Task end, end cause and packet timestamp capture of the link engine
`timescale 1ns/100ps
module rtec_task_end #(
    parameter int TIMER_W = 24
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire rtec_pkg::rtec_bus_t i_bus,
    output logic [7:0] o_rdata,
    input wire logic i_task_start,
    input wire logic i_halt_cmd,
    input wire logic i_unknown_cmd,
    input wire logic i_finish,
    input wire rtec_pkg::rtec_fin_t i_finish_cause,
    input wire logic i_packet_active,
    input wire rtec_pkg::rtec_pkt_t i_pkt,
    input wire logic [TIMER_W-1:0] i_timer,
    output logic o_running,
    output logic o_sem0_held,
    output logic o_sem1_held,
    output logic o_synth_on,
    output logic o_program_freq,
    output logic o_task_finished_irq,
    output logic o_packet_abort_irq,
    output logic [TIMER_W-1:0] o_capture
);
    // ==========================================================
    // Parameter checks
    initial begin
        if (TIMER_W < 1 || TIMER_W > 32) begin
            $error("TIMER_W must be 1 to 32");
        end
    end

    // ==========================================================
    // State
    typedef struct packed {
        rtec_pkg::rtec_state_t state;
        logic run;
        logic [7:0] radio_configuration;
        logic [7:0] channel;
        logic [7:0] task_end_reason;
        logic sem0;
        logic sem1;
        logic synth;
        logic prog;
        logic done_irq;
        logic abort_irq;
        logic [TIMER_W-1:0] capture;
        logic [7:0] rdata;
    } rtec_state_st_t;

    rtec_state_st_t st_reg;
    rtec_state_st_t st_next;

    logic tx_fire;
    logic rx_fire;
    logic abort_now;
    logic [7:0] fin_code;
    logic [TIMER_W-1:0] tx_stamp_reg;
    logic [TIMER_W-1:0] rx_stamp_reg;

    // ==========================================================
    // Capture units, one per direction
    rtec_capture u_tx_cap (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_select(st_reg.radio_configuration[rtec_pkg::TX_CAPTURE_SELECT_LSB +: 2]),
        .i_task_start(i_task_start),
        .i_sync(i_pkt.tx_sync),
        .i_end(i_pkt.tx_end),
        .o_fire(tx_fire)
    );

    rtec_capture u_rx_cap (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_select(st_reg.radio_configuration[rtec_pkg::RX_CAPTURE_SELECT_LSB +: 2]),
        .i_task_start(i_task_start),
        .i_sync(i_pkt.rx_sync),
        .i_end(i_pkt.rx_end),
        .o_fire(rx_fire)
    );

    // Timer sampled at the event, stored a cycle later with the fire
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_stamp_reg <= '0;
            rx_stamp_reg <= '0;
        end else begin
            tx_stamp_reg <= i_timer;
            rx_stamp_reg <= i_timer;
        end
    end

    assign abort_now = st_reg.state == rtec_pkg::RTEC_RUN &&
        (i_halt_cmd || i_unknown_cmd || i_task_start);

    // ==========================================================
    // End cause encoding
    always_comb begin
        unique case (i_finish_cause)
            rtec_pkg::RTEC_FIN_NORMAL: fin_code = rtec_pkg::END_NORMAL;
            rtec_pkg::RTEC_FIN_SYNC_STOP:
                fin_code = rtec_pkg::END_SYNC_WAIT_STOPPED;
            rtec_pkg::RTEC_FIN_SYNC_TIMEOUT:
                fin_code = rtec_pkg::END_SYNC_TIMEOUT;
            rtec_pkg::RTEC_FIN_BUSY:
                fin_code = rtec_pkg::END_CHANNEL_BUSY;
            rtec_pkg::RTEC_FIN_RETRY:
                fin_code = rtec_pkg::END_RETRY_LIMIT;
            rtec_pkg::RTEC_FIN_STOP:
                fin_code = rtec_pkg::END_STOPPED;
            rtec_pkg::RTEC_FIN_INTERNAL:
                fin_code = rtec_pkg::ERR_INTERNAL_PROGRAM;
            rtec_pkg::RTEC_FIN_BAD_CMD:
                fin_code = rtec_pkg::ERR_UNKNOWN_COMMAND;
            rtec_pkg::RTEC_FIN_SEM:
                fin_code = rtec_pkg::ERR_SEMAPHORE_UNAVAILABLE;
            rtec_pkg::RTEC_FIN_PARAM:
                fin_code = rtec_pkg::ERR_BAD_PARAMETER;
            rtec_pkg::RTEC_FIN_TXFIFO:
                fin_code = rtec_pkg::ERR_TX_FIFO_EMPTY;
            rtec_pkg::RTEC_FIN_RXFIFO:
                fin_code = rtec_pkg::ERR_RX_FIFO_OVERFULL;
            rtec_pkg::RTEC_FIN_MODUNF:
                fin_code = rtec_pkg::ERR_MODULATOR_UNDERFLOW;
            // Illegal encodings count as an internal fault
            default: fin_code = rtec_pkg::ERR_INTERNAL_PROGRAM;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.done_irq = 1'b0;
        st_next.abort_irq = 1'b0;
        st_next.prog = 1'b0;
        st_next.rdata = 8'h00;
        // Single stored value, direction not recorded
        if (tx_fire) begin
            st_next.capture = tx_stamp_reg;
        end
        if (rx_fire) begin
            st_next.capture = rx_stamp_reg;
        end
        unique case (st_reg.state)
            rtec_pkg::RTEC_IDLE, rtec_pkg::RTEC_HALT: begin
                if (i_task_start) begin
                    st_next.state = rtec_pkg::RTEC_RUN;
                    st_next.sem0 = 1'b1;
                    st_next.sem1 = 1'b1;
                    st_next.synth = 1'b1;
                    // Index 127 keeps the running synthesizer setting
                    st_next.prog = st_reg.channel[6:0] !=
                        rtec_pkg::FREQ_KEEP;
                end
                if (i_halt_cmd) begin
                    st_next.synth = 1'b0;
                end
            end
            rtec_pkg::RTEC_RUN: begin
                if (abort_now) begin
                    st_next.task_end_reason = rtec_pkg::END_ABORTED;
                    st_next.abort_irq = i_packet_active;
                end else if (i_finish) begin
                    st_next.task_end_reason = fin_code;
                end
                if (abort_now || i_finish) begin
                    st_next.state = rtec_pkg::RTEC_HALT;
                    st_next.sem0 = 1'b0;
                    st_next.sem1 = 1'b0;
                    st_next.done_irq = 1'b1;
                    st_next.synth = !i_halt_cmd &&
                        st_reg.channel[rtec_pkg::KEEP_SYNTH_BIT];
                end
            end
            default: st_next.state = rtec_pkg::RTEC_IDLE;
        endcase
        // Registered copy keeps the running output straight from a flop
        st_next.run = st_next.state == rtec_pkg::RTEC_RUN;
        // Register port
        if (i_bus.wr) begin
            if (i_bus.addr == rtec_pkg::ADDR_RADIO_CONFIGURATION) begin
                st_next.radio_configuration = i_bus.wdata;
            end
            if (i_bus.addr == rtec_pkg::ADDR_CHANNEL) begin
                st_next.channel = i_bus.wdata;
            end
        end
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                rtec_pkg::ADDR_RADIO_CONFIGURATION:
                    st_next.rdata = st_reg.radio_configuration;
                rtec_pkg::ADDR_CHANNEL: st_next.rdata = st_reg.channel;
                rtec_pkg::ADDR_TASK_END_REASON:
                    st_next.rdata = st_reg.task_end_reason;
                rtec_pkg::ADDR_STATUS:
                    st_next.rdata = {5'h00, st_reg.synth,
                        st_reg.state == rtec_pkg::RTEC_RUN,
                        st_reg.state != rtec_pkg::RTEC_RUN};
                // Low byte only; wider timer read via o_capture
                rtec_pkg::ADDR_CAPTURE: st_next.rdata = 8'(st_reg.capture);
                default: st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
            st_reg.state <= rtec_pkg::RTEC_IDLE;
            st_reg.radio_configuration <= rtec_pkg::RADIO_CONF_RESET;
            st_reg.channel <= rtec_pkg::CHANNEL_RESET;
            st_reg.task_end_reason <= rtec_pkg::END_REASON_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rdata = st_reg.rdata;
    assign o_running = st_reg.run;
    assign o_sem0_held = st_reg.sem0;
    assign o_sem1_held = st_reg.sem1;
    assign o_synth_on = st_reg.synth;
    assign o_program_freq = st_reg.prog;
    assign o_task_finished_irq = st_reg.done_irq;
    assign o_packet_abort_irq = st_reg.abort_irq;
    assign o_capture = st_reg.capture;

    // ==========================================================
    // Checks
    sequence s_finish_req;
        st_reg.state == rtec_pkg::RTEC_RUN && i_finish && !abort_now;
    endsequence

    sequence s_halted_clean;
        o_task_finished_irq && !o_sem0_held && !o_sem1_held && !o_running;
    endsequence

    property p_task_end;
        @(posedge i_clock) disable iff (!i_nrst)
        s_finish_req |=> s_halted_clean;
    endproperty
    a_task_end: assert property (p_task_end)
        else $error("task end did not halt cleanly");

    property p_end_code;
        @(posedge i_clock) disable iff (!i_nrst)
        s_finish_req |=> o_running == 1'b0 ##0
            st_reg.task_end_reason == $past(fin_code);
    endproperty
    a_end_code: assert property (p_end_code)
        else $error("end cause not stored");

    property p_abort_code;
        @(posedge i_clock) disable iff (!i_nrst)
        abort_now |=> st_reg.task_end_reason == rtec_pkg::END_ABORTED &&
            o_packet_abort_irq == $past(i_packet_active);
    endproperty
    a_abort_code: assert property (p_abort_code)
        else $error("abort handling wrong");

    property p_reason_stable;
        @(posedge i_clock) disable iff (!i_nrst)
        st_reg.state == rtec_pkg::RTEC_HALT && !i_task_start
            |=> $stable(st_reg.task_end_reason);
    endproperty
    a_reason_stable: assert property (p_reason_stable)
        else $error("end cause changed while halted");

    property p_keep_synth;
        @(posedge i_clock) disable iff (!i_nrst)
        s_finish_req ##0 st_reg.channel[rtec_pkg::KEEP_SYNTH_BIT] &&
            !i_halt_cmd |=> o_synth_on;
    endproperty
    a_keep_synth: assert property (p_keep_synth)
        else $error("synthesizer dropped despite keep bit");

    property p_halt_synth;
        @(posedge i_clock) disable iff (!i_nrst)
        i_halt_cmd && !i_task_start |=> !o_synth_on;
    endproperty
    a_halt_synth: assert property (p_halt_synth)
        else $error("halt did not stop synthesizer");

    property p_tx_start_cap;
        @(posedge i_clock) disable iff (!i_nrst)
        st_reg.radio_configuration[1:0] == rtec_pkg::CAP_START_ALL &&
            i_pkt.tx_sync && !i_bus.wr ##1 !rx_fire
            |=> o_capture == $past(i_timer, 2);
    endproperty
    a_tx_start_cap: assert property (p_tx_start_cap)
        else $error("start capture value wrong");

    property p_cap_off;
        @(posedge i_clock) disable iff (!i_nrst)
        st_reg.radio_configuration[3:0] == 4'h0 && !i_bus.wr
            |=> ##1 $stable(o_capture);
    endproperty
    a_cap_off: assert property (p_cap_off)
        else $error("capture while both directions off");

    property p_freq_keep;
        @(posedge i_clock) disable iff (!i_nrst)
        !o_running && i_task_start &&
            st_reg.channel[6:0] == rtec_pkg::FREQ_KEEP |=> !o_program_freq;
    endproperty
    a_freq_keep: assert property (p_freq_keep)
        else $error("frequency programmed for index 127");
endmodule : rtec_task_end

/* tb/testbench.sv */
// Self-checking bench for the task end and capture block
`timescale 1ns/100ps
module testbench;
    // ==========================================================
    // Signals and model state
    logic i_clock;
    logic i_nrst;
    rtec_pkg::rtec_bus_t bus;
    logic [7:0] rdata;
    logic task_start, halt_cmd, unknown_cmd, finish, packet_active;
    rtec_pkg::rtec_fin_t fin_cause;
    rtec_pkg::rtec_pkt_t pkt_in;
    logic [23:0] timer;
    logic [23:0] capture;
    logic running, sem0, sem1, synth, prog_freq, done_irq, abort_irq;
    logic [15:0] lfsr;
    logic [23:0] mcap;
    logic [7:0] cause_tab [14];
    int sel [2];
    int arm [2];
    int fails;
    int checks_done;

    rtec_task_end #(.TIMER_W(24)) i_dut (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_bus(bus), .o_rdata(rdata),
        .i_task_start(task_start), .i_halt_cmd(halt_cmd),
        .i_unknown_cmd(unknown_cmd), .i_finish(finish),
        .i_finish_cause(fin_cause), .i_packet_active(packet_active),
        .i_pkt(pkt_in), .i_timer(timer), .o_running(running),
        .o_sem0_held(sem0), .o_sem1_held(sem1), .o_synth_on(synth),
        .o_program_freq(prog_freq), .o_task_finished_irq(done_irq),
        .o_packet_abort_irq(abort_irq), .o_capture(capture)
    );

    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    // ==========================================================
    // Random timer, so a stale capture never matches by luck
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    always @(posedge i_clock) begin
        if (!i_nrst) begin
            lfsr <= 16'hcfc6; // Seed 53190
        end else begin
            lfsr <= lfsr_next(lfsr);
        end
        timer <= {lfsr, lfsr[7:0]};
    end

    // ==========================================================
    // Tasks
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge i_clock);
        bus.wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input string n, input logic [3:0] a,
                          input logic [7:0] e);
        @(posedge i_clock);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge i_clock);
        bus.rd <= 1'b0;
        @(negedge i_clock);
        chk(n, 32'(rdata), 32'(e));
    endtask : rd_chk

    // Kind 0 start, 1 halt, 2 unknown command, 3 finish with cause c
    task automatic cmd(input int k, input int c);
        @(posedge i_clock);
        task_start <= (k == 0);
        halt_cmd <= (k == 1);
        unknown_cmd <= (k == 2);
        finish <= (k == 3);
        fin_cause <= rtec_pkg::rtec_fin_t'(c[3:0]);
        @(posedge i_clock);
        {task_start, halt_cmd, unknown_cmd, finish} <= 4'h0;
        @(negedge i_clock);
        if (k == 0) begin
            arm[0] = 1;
            arm[1] = 1;
        end
    endtask : cmd

    // Event 0 tx sync, 1 tx end, 2 rx sync, 3 rx end
    task automatic pkt(input int b);
        int d;
        logic sync;
        d = b / 2;
        sync = (b % 2) == 0;
        @(posedge i_clock);
        pkt_in <= rtec_pkg::rtec_pkt_t'(4'h8 >> b);
        @(negedge i_clock);
        if ((sel[d] == 1 && sync) || (sel[d] == 2 && !sync)
            || (sel[d] == 3 && sync && arm[d] == 1)) mcap = timer;
        if (sel[d] == 3 && !sync) arm[d] = 0;
        @(posedge i_clock);
        pkt_in <= '0;
        repeat (3) @(negedge i_clock);
        chk("capture", 32'(capture), 32'(mcap));
    endtask : pkt

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    // ==========================================================
    // Watchdog, well above the several hundred cycles the tests need
    initial begin
        repeat (8000) @(posedge i_clock);
        fails++;
        close_out();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] ch;
        i_nrst = 1'b0;
        bus = '0;
        {task_start, halt_cmd, unknown_cmd, finish, packet_active} = 5'h0;
        fin_cause = rtec_pkg::RTEC_FIN_NORMAL;
        pkt_in = '0;
        mcap = '0;
        sel = '{0, 0};
        arm = '{0, 0};
        fails = 0;
        checks_done = 0;
        cause_tab = '{rtec_pkg::END_NORMAL, rtec_pkg::END_SYNC_WAIT_STOPPED,
            rtec_pkg::END_SYNC_TIMEOUT, rtec_pkg::END_CHANNEL_BUSY,
            rtec_pkg::END_RETRY_LIMIT, rtec_pkg::END_STOPPED,
            rtec_pkg::ERR_INTERNAL_PROGRAM, rtec_pkg::ERR_UNKNOWN_COMMAND,
            rtec_pkg::ERR_SEMAPHORE_UNAVAILABLE, rtec_pkg::ERR_BAD_PARAMETER,
            rtec_pkg::ERR_TX_FIFO_EMPTY, rtec_pkg::ERR_RX_FIFO_OVERFULL,
            rtec_pkg::ERR_MODULATOR_UNDERFLOW, rtec_pkg::ERR_INTERNAL_PROGRAM};
        repeat (2) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(negedge i_clock);
        chk("rst_out", 32'({running, sem0, sem1, synth, done_irq}), 32'h0);
        chk("rst_cap", 32'(capture), 32'h0);
        for (int b = 0; b < 4; b++) pkt(b);
        rd_chk("conf_rst", 4'h0, rtec_pkg::RADIO_CONF_RESET);
        rd_chk("chan_rst", 4'h1, rtec_pkg::CHANNEL_RESET);
        rd_chk("unmapped", 4'hf, 8'h00);
        wr_reg(4'hf, 8'h5a);
        wr_reg(rtec_pkg::ADDR_TASK_END_REASON, 8'h77);
        rd_chk("reason_ro", rtec_pkg::ADDR_TASK_END_REASON, 8'h00);
        wr_reg(rtec_pkg::ADDR_RADIO_CONFIGURATION, 8'h0e);
        rd_chk("conf", rtec_pkg::ADDR_RADIO_CONFIGURATION, 8'h0e);
        $display("test registers done");
        for (int i = 0; i < 14; i++) begin
            ch = {i[0], (i[1] ? 7'h7f : 7'(i * 3))};
            wr_reg(rtec_pkg::ADDR_CHANNEL, ch);
            cmd(0, 0);
            chk("start", 32'({running, sem0, sem1, synth}), 32'hf);
            chk("prog", 32'(prog_freq), 32'(ch[6:0] != 7'h7f));
            if (i == 0) rd_chk("status", rtec_pkg::ADDR_STATUS, 8'h06);
            cmd(3, i);
            chk("done", 32'(done_irq), 32'h1);
            chk("stop", 32'({running, sem0, sem1, abort_irq}), 32'h0);
            chk("keep", 32'(synth), 32'(ch[7]));
            rd_chk("reason", 4'h2, cause_tab[i]);
            if (ch[7]) begin
                cmd(1, 0);
                chk("synth_off", 32'(synth), 32'h0);
                rd_chk("reason_hold", 4'h2, cause_tab[i]);
            end
        end
        $display("test end causes done");
        wr_reg(rtec_pkg::ADDR_CHANNEL, 8'h05);
        for (int j = 0; j < 6; j++) begin
            @(posedge i_clock);
            packet_active <= j[0];
            cmd(0, 0);
            cmd((j / 2 == 2) ? 0 : 1 + j / 2, 0);
            chk("ab_done", 32'(done_irq), 32'h1);
            chk("ab_irq", 32'(abort_irq), 32'(j[0]));
            chk("ab_run", 32'({running, synth}), 32'h0);
            rd_chk("ab_reason", 4'h2, rtec_pkg::END_ABORTED);
        end
        packet_active <= 1'b0;
        $display("test aborts done");
        for (int s = 0; s < 4; s++) begin
            sel[0] = s;
            sel[1] = 3 - s;
            wr_reg(rtec_pkg::ADDR_RADIO_CONFIGURATION, 8'(((3 - s) << 2) | s));
            for (int t = 0; t < 2; t++) begin
                cmd(0, 0);
                for (int b = 0; b < 6; b++) pkt((b / 3) * 2 + (b % 3 == 1));
                cmd(3, 0);
                rd_chk("cap_byte", rtec_pkg::ADDR_CAPTURE, mcap[7:0]);
            end
        end
        $display("test capture done");
        cmd(0, 0);
        cmd(2, 0);
        cmd(0, 0);
        @(posedge i_clock);
        i_nrst <= 1'b0;
        @(negedge i_clock);
        chk("rst2", 32'({running, sem0, sem1, synth}), 32'h0);
        chk("rst2_cap", 32'(capture), 32'h0);
        @(posedge i_clock);
        i_nrst <= 1'b1;
        rd_chk("rst2_reason", 4'h2, rtec_pkg::END_REASON_RESET);
        rd_chk("rst2_conf", 4'h0, rtec_pkg::RADIO_CONF_RESET);
        $display("test second reset done");
        close_out();
    end
endmodule : testbench
